// ---- design/alu_pkg.sv ----
package alu_pkg;

  // ********************************************************
  // widths and types
  // ********************************************************
  localparam int ACC_W  = 32;
  localparam int WORD_W = 16;
  localparam int ADDR_W = 16;

  typedef logic [ACC_W-1:0]  alu_acc_t;
  typedef logic [WORD_W-1:0] alu_word_t;
  typedef logic [ADDR_W-1:0] alu_addr_t;

  // ********************************************************
  // operation, operand source and sequencer state encodings
  // ********************************************************
  typedef enum logic [1:0] {
    OP_AND = 2'h0,
    OP_OR  = 2'h1,
    OP_XOR = 2'h2
  } alu_op_e;

  typedef enum logic [1:0] {
    SRC_DIRECT  = 2'h0,
    SRC_POINTER = 2'h1,
    SRC_IMM     = 2'h2
  } alu_src_e;

  typedef enum logic [1:0] {
    ST_IDLE      = 2'h0,
    ST_PTR_WAIT  = 2'h1,
    ST_WORD_WAIT = 2'h2,
    ST_EXEC      = 2'h3
  } alu_state_e;

  // ********************************************************
  // reset values
  // ********************************************************
  localparam alu_acc_t  ACC_RST      = 32'h0000_0000;
  localparam alu_addr_t ADDR_RST     = 16'h0000;
  localparam logic      ZERO_FLG_RST = 1'h0;
  localparam logic      NEG_FLG_RST  = 1'h0;

  // ********************************************************
  // sign bit position, high-half fill and next-word step
  // ********************************************************
  localparam int SIGN_BIT = ACC_W - 1;
  localparam alu_word_t HI_ZERO = 16'h0000;
  localparam alu_addr_t NEXT_WORD = 16'h0001;

endpackage

// ---- design/alu_dp_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface alu_dp_if;
  import alu_pkg::*;

  logic      clr;
  logic      wr;
  logic      imm_ld;
  alu_word_t word;
  alu_acc_t  imm;
  alu_acc_t  operand;
  alu_op_e   op;
  logic      wide;
  alu_acc_t  acc;
  alu_acc_t  result;
  logic      zero;
  logic      neg;

  modport ctl  (output clr, wr, imm_ld, word, imm, op, wide, acc,
                input  operand, result, zero, neg);
  modport asm  (input  clr, wr, imm_ld, word, imm,
                output operand);
  modport core (input  op, wide, acc, operand,
                output result, zero, neg);
endinterface
`default_nettype wire

// ---- design/alu_opnd_asm.sv ----
`timescale 1ns/1ps
`default_nettype none
module alu_opnd_asm
  import alu_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // datapath
  alu_dp_if.asm    dp
);

  typedef struct packed {
    alu_acc_t operand;
    logic     half;
  } alu_asm_s;

  alu_asm_s st_ff;
  alu_asm_s nxt_st;

  // ********************************************************
  // operand assembly
  // ********************************************************
  always_comb begin
    nxt_st = st_ff;
    if (dp.imm_ld) begin
      nxt_st.operand = dp.imm;
      nxt_st.half    = 1'b0;
    end else if (dp.clr) begin
      nxt_st.operand = ACC_RST;
      nxt_st.half    = 1'b0;
    end else if (dp.wr) begin
      // lower address fills low half, next word the high half
      if (!st_ff.half) begin
        nxt_st.operand[WORD_W-1:0] = dp.word;
      end else begin
        nxt_st.operand[ACC_W-1:WORD_W] = dp.word;
      end
      nxt_st.half = ~st_ff.half;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      st_ff <= '{operand: ACC_RST, half: 1'b0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign dp.operand = st_ff.operand;

endmodule // alu_opnd_asm
`default_nettype wire

// ---- design/alu_logic_core.sv ----
`timescale 1ns/1ps
`default_nettype none
module alu_logic_core
  import alu_pkg::*;
(
  // datapath
  alu_dp_if.core dp
);

  alu_acc_t opnd;

  // ********************************************************
  // logic operation and status
  // ********************************************************
  always_comb begin
    // narrow forms see a zero-extended memory word
    opnd = dp.wide ? dp.operand : {HI_ZERO, dp.operand[WORD_W-1:0]};
    unique case (dp.op)
      OP_AND: dp.result = dp.acc & opnd;
      OP_OR:  dp.result = dp.acc | opnd;
      OP_XOR: dp.result = dp.acc ^ opnd;
      default: dp.result = dp.acc;
    endcase
    dp.zero = (dp.result == ACC_RST);
    dp.neg  = dp.result[SIGN_BIT];
  end

endmodule // alu_logic_core
`default_nettype wire

// ---- design/alu_unit.sv ----
`timescale 1ns/1ps
`default_nettype none
module alu_unit
  import alu_pkg::*;
(
  // clock and reset
  input  wire logic          CLK,
  input  wire logic          RESET,
  // operation request
  input  wire logic          OP_VALID,
  input  wire logic [1:0]    OP_CODE,
  input  wire logic          OP_WIDE,
  input  wire logic [1:0]    OP_SRC,
  input  wire alu_pkg::alu_addr_t OP_ADDR,
  input  wire alu_pkg::alu_acc_t  OP_IMM,
  output var  logic          BUSY,
  output var  logic          DONE,
  output var  logic          REJECT,
  // accumulator load
  input  wire logic          ACC_LOAD,
  input  wire alu_pkg::alu_acc_t  ACC_LOAD_DATA,
  // word memory read port
  output var  logic          MEM_RD_REQ,
  output var  alu_pkg::alu_addr_t MEM_ADDR,
  input  wire logic          MEM_RD_VALID,
  input  wire alu_pkg::alu_word_t MEM_RD_DATA,
  // accumulator and status
  output var  alu_pkg::alu_acc_t  ACC,
  output var  logic          ZERO_RESULT_FLAG,
  output var  logic          NEGATIVE_RESULT_FLAG
);
  import alu_pkg::*;

  // ********************************************************
  // state
  // ********************************************************
  typedef struct packed {
    alu_state_e state;
    alu_op_e    op;
    logic       wide;
    logic       word_hi;
    alu_acc_t   acc;
    logic       zero;
    logic       neg;
    logic       busy;
    logic       done;
    logic       reject;
    logic       mem_req;
    alu_addr_t  mem_addr;
  } alu_state_s;

  localparam alu_state_s ST_RST = '{
    state: ST_IDLE, op: OP_AND, wide: 1'b0, word_hi: 1'b0,
    acc: ACC_RST, zero: ZERO_FLG_RST, neg: NEG_FLG_RST, busy: 1'b0,
    done: 1'b0, reject: 1'b0, mem_req: 1'b0, mem_addr: ADDR_RST};

  alu_state_s st_ff;
  alu_state_s nxt_st;
  logic       op_legal;
  logic       src_legal;
  logic       take_op;

  alu_dp_if dp ();

  // ********************************************************
  // sub-blocks
  // ********************************************************
  alu_opnd_asm u_asm (
    .clk   (CLK),
    .reset (RESET),
    .dp    (dp.asm)
  );

  alu_logic_core u_core (
    .dp (dp.core)
  );

  // ********************************************************
  // request decode
  // ********************************************************
  always_comb begin
    op_legal  = (OP_CODE == OP_AND) || (OP_CODE == OP_OR) || (OP_CODE == OP_XOR);
    // immediate only for wide forms
    src_legal = (OP_SRC == SRC_DIRECT) || (OP_SRC == SRC_POINTER)
             || ((OP_SRC == SRC_IMM) && OP_WIDE);
    take_op   = (st_ff.state == ST_IDLE) && OP_VALID;
  end

  // datapath control
  always_comb begin
    dp.clr    = take_op;
    dp.imm_ld = take_op && op_legal && src_legal && (OP_SRC == SRC_IMM);
    dp.imm    = OP_IMM;
    dp.wr     = (st_ff.state == ST_WORD_WAIT) && MEM_RD_VALID;
    dp.word   = MEM_RD_DATA;
    dp.op     = st_ff.op;
    dp.wide   = st_ff.wide;
    dp.acc    = st_ff.acc;
  end

  // ********************************************************
  // sequencer
  // ********************************************************
  always_comb begin
    nxt_st         = st_ff;
    nxt_st.done    = 1'b0;
    nxt_st.reject  = 1'b0;
    nxt_st.mem_req = 1'b0;
    unique case (st_ff.state)
      ST_IDLE: begin
        if (OP_VALID) begin
          if (!op_legal || !src_legal) begin
            nxt_st.reject = 1'b1;
          end else begin
            nxt_st.op      = alu_op_e'(OP_CODE);
            nxt_st.wide    = OP_WIDE;
            nxt_st.word_hi = 1'b0;
            nxt_st.busy    = 1'b1;
            if (OP_SRC == SRC_IMM) begin
              nxt_st.state = ST_EXEC;
            end else begin
              nxt_st.mem_req  = 1'b1;
              nxt_st.mem_addr = OP_ADDR;
              nxt_st.state    = (OP_SRC == SRC_POINTER) ? ST_PTR_WAIT
                                                         : ST_WORD_WAIT;
            end
          end
        end else if (ACC_LOAD) begin
          nxt_st.acc = ACC_LOAD_DATA;
        end
      end
      ST_PTR_WAIT: begin
        if (MEM_RD_VALID) begin
          // pointer word holds the operand address
          nxt_st.mem_req  = 1'b1;
          nxt_st.mem_addr = MEM_RD_DATA;
          nxt_st.state    = ST_WORD_WAIT;
        end
      end
      ST_WORD_WAIT: begin
        if (MEM_RD_VALID) begin
          if (st_ff.wide && !st_ff.word_hi) begin
            nxt_st.word_hi  = 1'b1;
            nxt_st.mem_req  = 1'b1;
            nxt_st.mem_addr = st_ff.mem_addr + NEXT_WORD;
          end else begin
            nxt_st.state = ST_EXEC;
          end
        end
      end
      ST_EXEC: begin
        nxt_st.acc   = dp.result;
        nxt_st.zero  = dp.zero;
        nxt_st.neg   = dp.neg;
        nxt_st.done  = 1'b1;
        nxt_st.busy  = 1'b0;
        nxt_st.state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      st_ff <= ST_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ********************************************************
  // outputs
  // ********************************************************
  always_comb begin
    BUSY                 = st_ff.busy;
    DONE                 = st_ff.done;
    REJECT               = st_ff.reject;
    MEM_RD_REQ           = st_ff.mem_req;
    MEM_ADDR             = st_ff.mem_addr;
    ACC                  = st_ff.acc;
    ZERO_RESULT_FLAG     = st_ff.zero;
    NEGATIVE_RESULT_FLAG = st_ff.neg;
  end

  // ********************************************************
  // checks
  // ********************************************************
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RESET);

  alu_acc_t chk_opnd;
  assign chk_opnd = st_ff.wide ? dp.operand : {HI_ZERO, dp.operand[WORD_W-1:0]};

  sequence s_exec_op(alu_op_e o, logic w);
    (st_ff.state == ST_EXEC) && (st_ff.op == o) && (st_ff.wide == w);
  endsequence

  sequence s_word_back;
    (st_ff.state == ST_WORD_WAIT) && MEM_RD_VALID;
  endsequence

  sequence s_ptr_back;
    (st_ff.state == ST_PTR_WAIT) && MEM_RD_VALID;
  endsequence

  and_narrow_a: assert property (s_exec_op(OP_AND, 1'b0) |=>
    ACC == ($past(st_ff.acc) & {HI_ZERO, $past(dp.operand[WORD_W-1:0])}) && DONE)
    else $error("narrow and result wrong");
  and_wide_a: assert property (s_exec_op(OP_AND, 1'b1) |=>
    ACC == ($past(st_ff.acc) & $past(dp.operand)))
    else $error("wide and result wrong");
  or_narrow_a: assert property (s_exec_op(OP_OR, 1'b0) |=>
    ACC == ($past(st_ff.acc) | {HI_ZERO, $past(dp.operand[WORD_W-1:0])}))
    else $error("narrow or result wrong");
  or_wide_a: assert property (s_exec_op(OP_OR, 1'b1) |=>
    ACC == ($past(st_ff.acc) | $past(dp.operand)))
    else $error("wide or result wrong");
  xor_narrow_a: assert property (s_exec_op(OP_XOR, 1'b0) |=>
    ACC == ($past(st_ff.acc) ^ {HI_ZERO, $past(dp.operand[WORD_W-1:0])}))
    else $error("narrow xor result wrong");
  xor_wide_a: assert property (s_exec_op(OP_XOR, 1'b1) |=>
    ACC == ($past(st_ff.acc) ^ $past(dp.operand)))
    else $error("wide xor result wrong");
  imm_wide_a: assert property ((take_op && OP_WIDE && OP_SRC == SRC_IMM
    && op_legal) ##1 1'b1 |-> dp.operand == $past(OP_IMM) ##1 DONE)
    else $error("immediate operand not used");
  zero_flag_a: assert property (DONE |-> ZERO_RESULT_FLAG == (ACC == ACC_RST))
    else $error("zero flag mismatch");
  neg_flag_a: assert property (DONE |->
    NEGATIVE_RESULT_FLAG == ACC[SIGN_BIT] ##1
    NEGATIVE_RESULT_FLAG == $past(NEGATIVE_RESULT_FLAG))
    else $error("negative flag mismatch");
  ptr_addr_a: assert property (s_ptr_back |=> MEM_RD_REQ
    && MEM_ADDR == $past(MEM_RD_DATA) && st_ff.state == ST_WORD_WAIT)
    else $error("pointer not followed");
  hi_word_a: assert property (s_word_back ##0 (st_ff.wide && !st_ff.word_hi)
    |=> MEM_RD_REQ && MEM_ADDR == $past(MEM_ADDR) + NEXT_WORD
    ##1 (!MEM_RD_REQ) [*1])
    else $error("high word address wrong");
  lo_half_a: assert property (s_word_back ##0 (st_ff.wide && !st_ff.word_hi)
    |=> dp.operand[WORD_W-1:0] == $past(MEM_RD_DATA))
    else $error("low half not from first word");

endmodule // alu_unit
`default_nettype wire

// ---- tb/alu_mem_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module alu_mem_model
  import alu_pkg::*;
(
  // clock and reset
  input  wire logic               clk,
  input  wire logic               reset,
  // read port
  input  wire logic               rd_req,
  input  wire alu_pkg::alu_addr_t addr,
  output var  logic               rd_valid,
  output var  alu_pkg::alu_word_t rd_data,
  // answer delay in cycles
  input  wire logic [1:0]         lat
);
  import alu_pkg::*;
  alu_word_t  mem [0:255];
  logic [1:0] cnt_ff;

  // ****************************************
  // delayed answer, zero delay answers in the request cycle
  // ****************************************
  always_ff @(posedge clk) begin
    if (reset) cnt_ff <= 2'h0;
    else if (rd_req && lat != 2'h0) cnt_ff <= lat;
    else if (cnt_ff != 2'h0) cnt_ff <= cnt_ff - 2'h1;
  end

  assign rd_valid = (lat == 2'h0) ? rd_req : (cnt_ff == 2'h1);
  // data line shows garbage outside the answer cycle
  assign rd_data  = rd_valid ? mem[addr[7:0]] : ~mem[addr[7:0]];
endmodule // alu_mem_model
`default_nettype wire

// ---- tb/accumulator_logic_unit_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module accumulator_logic_unit_tb;
  import alu_pkg::*;
  typedef struct packed { logic rej; alu_acc_t acc; } alu_exp_s;
  logic       clk, reset, op_valid, op_wide, acc_load, busy, done, reject;
  logic       mem_rd_req, mem_rd_valid, zf, nf;
  logic [1:0] op_code, op_src, lat;
  alu_addr_t  op_addr, mem_addr;
  alu_acc_t   op_imm, acc_load_data, acc, exp_acc;
  alu_word_t  mem_rd_data;
  alu_exp_s   exp_q[$];
  alu_exp_s   e;
  int         mismatches, total_checks, seed;

  alu_unit uut (.CLK(clk), .RESET(reset), .OP_VALID(op_valid), .OP_CODE(op_code),
    .OP_WIDE(op_wide), .OP_SRC(op_src), .OP_ADDR(op_addr), .OP_IMM(op_imm), .BUSY(busy),
    .DONE(done), .REJECT(reject), .ACC_LOAD(acc_load), .ACC_LOAD_DATA(acc_load_data),
    .MEM_RD_REQ(mem_rd_req), .MEM_ADDR(mem_addr), .MEM_RD_VALID(mem_rd_valid),
    .MEM_RD_DATA(mem_rd_data), .ACC(acc), .ZERO_RESULT_FLAG(zf),
    .NEGATIVE_RESULT_FLAG(nf));
  alu_mem_model mem_m (.clk(clk), .reset(reset), .rd_req(mem_rd_req), .addr(mem_addr),
    .rd_valid(mem_rd_valid), .rd_data(mem_rd_data), .lat(lat));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // ****************************************
  // tasks
  // ****************************************
  task automatic report_and_stop();
    if (mismatches == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic fail(input string msg);
    mismatches++;
    $display("[FAIL] %0t %s", $time, msg);
  endtask

  task automatic wait_idle();
    for (int n = 0; busy !== 1'b0; n++) begin
      if (n > 100) begin
        fail("unit never idle");
        report_and_stop();
      end
      @(negedge clk);
    end
  endtask

  task automatic load(input alu_acc_t v);
    wait_idle();
    acc_load      = 1'b1;
    acc_load_data = v;
    exp_acc       = v;
    @(negedge clk);
    acc_load = 1'b0;
  endtask

  task automatic issue(input logic [1:0] code, input logic wide, input logic [1:0] src,
                       input alu_addr_t addr, input alu_acc_t imm);
    alu_acc_t  opnd;
    alu_addr_t a;
    logic      ok;
    wait_idle();
    ok   = code != 2'h3 && src != 2'h3 && !(src == 2'h2 && !wide);
    a    = (src == 2'h1) ? mem_m.mem[addr[7:0]] : addr;
    opnd = (src == 2'h2) ? imm : {wide ? mem_m.mem[a[7:0] + 8'h1] : 16'h0, mem_m.mem[a[7:0]]};
    if (ok) exp_acc = code == 2'h0 ? exp_acc & opnd : code == 2'h1 ? exp_acc | opnd : exp_acc ^ opnd;
    exp_q.push_back({!ok, exp_acc});
    lat      = 2'($random(seed));
    op_code  = code;
    op_wide  = wide;
    op_src   = src;
    op_addr  = addr;
    op_imm   = imm;
    op_valid = 1'b1;
    @(negedge clk);
    op_valid = 1'b0;
    if (!ok) repeat (2) @(negedge clk);
  endtask

  task automatic chk_done(input alu_exp_s x);
    total_checks++;
    if (acc !== x.acc || zf !== (x.acc == 32'h0) || nf !== x.acc[SIGN_BIT] || reject !== 1'b0)
      fail($sformatf("result acc %h z %b n %b, want %h", acc, zf, nf, x.acc));
  endtask

  task automatic chk_reject(input alu_exp_s x);
    total_checks++;
    if (acc !== x.acc || done !== 1'b0) fail("refused request changed accumulator");
  endtask

  // ****************************************
  // result monitor, flags read in the result cycle
  // ****************************************
  always @(negedge clk) begin
    if (reset === 1'b0 && (done === 1'b1 || reject === 1'b1)) begin
      if (exp_q.size() == 0) fail("unexpected result");
      else begin
        e = exp_q.pop_front();
        if (e.rej) chk_reject(e);
        else chk_done(e);
      end
    end
  end

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    seed = 18009;
    mismatches = 0;
    total_checks = 0;
    {reset, op_valid, op_code, op_wide, op_src, op_addr, op_imm} = {1'b1, 54'h0};
    {acc_load, acc_load_data, lat, exp_acc} = 67'h0;
    for (int i = 0; i < 256; i++)
      mem_m.mem[i] = (i < 128) ? 16'($random(seed)) : 16'($random(seed) & 32'h7e);
    repeat (6) @(negedge clk);
    reset = 1'b0;
    issue(2'h1, 1'b1, 2'h2, 16'h0, 32'hffff_ffff);
    issue(2'h2, 1'b1, 2'h2, 16'h0, 32'hffff_ffff);
    issue(2'h0, 1'b0, 2'h2, 16'h0, 32'h1);
    issue(2'h3, 1'b0, 2'h0, 16'h0, 32'h0);
    issue(2'h0, 1'b1, 2'h3, 16'h0, 32'h0);
    for (int i = 0; i < 72; i++) begin
      if (i % 5 == 0) load(alu_acc_t'($random(seed)));
      issue(2'(i % 3), 1'(i / 3 % 2), 2'(i / 6 % 3),
            {8'h0, i / 6 % 3 == 1, 7'($random(seed))}, alu_acc_t'($random(seed)));
    end
    wait_idle();
    repeat (4) @(negedge clk);
    if (exp_q.size() != 0) fail("missing results");
    report_and_stop();
  end
endmodule // accumulator_logic_unit_tb
`default_nettype wire
